// *** hw/rfct_bp_timer.sv ***
// Back pressure duration timer driven by a 100 ns tick divider.
// Assumes start is a one-cycle pulse on the system clock.
`timescale 1ns/1ps
module rfct_bp_timer
    import rfct_pkg::*;
#(
    parameter int TICKS = TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset,
    rfct_timer_if.tmr tif
);

    function automatic logic [12:0] dur_ticks(input logic [3:0] c,
                                             input logic s100);
        logic [12:0] base;
        base = 13'h0000;
        if (c == BP_CODE_LONG_BASE) begin
            base = BP_CODE3_TICKS;
        end else if (c < BP_CODE_LONG_BASE) begin
            base = 13'(({9'h000, c} + 13'h0001) * BP_SHORT_TICKS);
        end else begin
            base = 13'(({9'h000, c} - {9'h000, BP_CODE_LONG_BASE})
                   * BP_LONG_TICKS);
        end
        return s100 ? base : 13'(base + BP_10M_TICKS);
    endfunction

    logic [12:0] remain_q, remain_d;
    logic [15:0] div_q, div_d;
    logic speed_q, speed_d;
    wire logic tick = (div_q == 16'(TICKS - 1));
    wire logic [12:0] loadVal = dur_ticks(tif.code, tif.speed100);

    assign tif.busy = (remain_q != 13'h0000);

    always_comb begin
        remain_d = remain_q;
        div_d = tick ? 16'h0000 : 16'(div_q + 16'h0001);
        speed_d = speed_q;
        if (tif.start) begin
            // A new trigger restarts the period and realigns the divider.
            remain_d = loadVal;
            speed_d = tif.speed100;
            div_d = 16'h0000;
        end else if (tick && tif.busy) begin
            remain_d = 13'(remain_q - 13'h0001);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            remain_q <= 13'h0000;
            div_q <= 16'h0000;
            speed_q <= 1'b0;
        end else begin
            remain_q <= remain_d;
            div_q <= div_d;
            speed_q <= speed_d;
        end
    end

    chk_load_duration: assert property (
        @(posedge clk_sys) disable iff (reset)
        tif.start |=> remain_q == $past(loadVal))
        else $error("back pressure period loaded with wrong length");

    chk_speed_latched: assert property (
        @(posedge clk_sys) disable iff (reset)
        tif.start |=> speed_q == $past(tif.speed100))
        else $error("link speed not captured at start of back pressure");

endmodule

// *** hw/rfct_top.sv ***
// Receive FIFO flow control trigger: pause requests and back pressure.
// Assumes MAC status inputs are on clk_sys; nothing here is asynchronous.
`timescale 1ns/1ps

module rfct_top
    import rfct_pkg::*;
#(
    parameter int BP_TICK_CYCLES = TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic flowCtlAnyFrame,
    input wire logic flowCtlOnGroupFrame,
    input wire logic flowCtlOnAllStationFrame,
    input wire logic flowCtlOnOwnFrame,
    input wire logic [7:0] flowHighMark,
    input wire logic [7:0] flowLowMark,
    input wire logic [3:0] backpressureTimeCode,
    input wire logic [LEVEL_W-1:0] rxFifoLevel,
    input wire logic fullDuplex,
    input wire logic speed100,
    input wire logic txEnable,
    input wire logic rxPreamble,
    input wire logic rxAddrDone,
    input wire logic rxIsGroup,
    input wire logic rxIsBroadcast,
    input wire logic rxIsOwn,
    input wire logic txWindow,
    output logic pauseReq,
    output logic pauseZero,
    output logic backpressure,
    output logic highReached
);

    ////////////////////////////////////////////////////////////////////////
    // Threshold decode

    wire logic [LEVEL_W-1:0] highBytes =
        LEVEL_W'({flowHighMark, {MARK_UNIT_SHIFT{1'b0}}});
    wire logic [LEVEL_W-1:0] lowBytes =
        LEVEL_W'({flowLowMark, {MARK_UNIT_SHIFT{1'b0}}});
    wire logic levelHigh = (rxFifoLevel >= highBytes);
    wire logic belowLow = (rxFifoLevel < lowBytes);

    ////////////////////////////////////////////////////////////////////////
    // Half duplex trigger

    // The selected-address path only exists when any-frame is clear.
    wire logic addrMatch = rxAddrDone &&
        ((flowCtlOnGroupFrame && rxIsGroup) ||
         (flowCtlOnAllStationFrame && rxIsBroadcast) ||
         (flowCtlOnOwnFrame && rxIsOwn));
    wire logic frameHit = flowCtlAnyFrame ? rxPreamble : addrMatch;
    wire logic hdTrig = !fullDuplex && txEnable && levelHigh
                        && frameHit;

    rfct_timer_if tif ();
    assign tif.start = hdTrig;
    assign tif.code = backpressureTimeCode;
    assign tif.speed100 = speed100;

    rfct_bp_timer #(
        .TICKS(BP_TICK_CYCLES)
    ) u_timer (
        .clk_sys(clk_sys),
        .reset(reset),
        .tif(tif)
    );

    ////////////////////////////////////////////////////////////////////////
    // Full duplex pause requests, jam and high status registers

    rfct_fd_state_type fd_q, fd_d;
    logic req_q, req_d;
    logic zero_q, zero_d;
    logic jam_q, jam_d;
    logic high_q;

    wire logic fdArmed = fullDuplex && flowCtlAnyFrame && txEnable;
    wire logic granted = req_q && txWindow;
    wire logic reqFree = !req_q || granted;
    wire logic askHigh = fdArmed && fd_q == FD_IDLE && levelHigh;
    wire logic askZero = fdArmed && fd_q == FD_PAUSED && belowLow;

    always_comb begin
        fd_d = fd_q;
        req_d = req_q;
        zero_d = zero_q;
        // A pending pause waits for a window instead of cutting a frame.
        if (granted) begin
            req_d = 1'b0;
        end
        if (askHigh && reqFree) begin
            req_d = 1'b1;
            zero_d = 1'b0;
            fd_d = FD_PAUSED;
        end else if (askZero && reqFree) begin
            req_d = 1'b1;
            zero_d = 1'b1;
            fd_d = FD_IDLE;
        end
        if (!txEnable) begin
            req_d = 1'b0;
            fd_d = FD_IDLE;
        end
    end

    assign jam_d = tif.busy && txEnable && !fullDuplex;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fd_q <= FD_IDLE;
            req_q <= 1'b0;
            zero_q <= 1'b0;
            jam_q <= 1'b0;
            high_q <= 1'b0;
        end else begin
            fd_q <= fd_d;
            req_q <= req_d;
            zero_q <= zero_d;
            jam_q <= jam_d;
            high_q <= levelHigh;
        end
    end

    assign pauseReq = req_q;
    assign pauseZero = zero_q;
    assign backpressure = jam_q;
    assign highReached = high_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    chk_any_preamble: assert property (
        @(posedge clk_sys) disable iff (reset)
        !fullDuplex && txEnable && flowCtlAnyFrame && levelHigh && rxPreamble
        |=> tif.busy)
        else $error("any-frame trigger missed on preamble");

    chk_fd_needs_any: assert property (
        @(posedge clk_sys) disable iff (reset)
        $rose(req_q) |-> $past(flowCtlAnyFrame) && $past(fullDuplex))
        else $error("pause requested without any-frame option");

    chk_fd_immediate: assert property (
        @(posedge clk_sys) disable iff (reset)
        askHigh && !req_q |=> req_q && !zero_q)
        else $error("pause not requested at threshold");

    chk_pause_held: assert property (
        @(posedge clk_sys) disable iff (reset)
        req_q && !txWindow && txEnable |=> req_q)
        else $error("pending pause dropped before transmit window");

    chk_addr_override: assert property (
        @(posedge clk_sys) disable iff (reset)
        flowCtlAnyFrame && !rxPreamble |-> !hdTrig)
        else $error("address selection used while any-frame is set");

    chk_high_status: assert property (
        @(posedge clk_sys) disable iff (reset)
        rxFifoLevel >= {flowHighMark, 6'h00} |=> highReached)
        else $error("high mark reached but not reported");

    chk_zero_pause: assert property (
        @(posedge clk_sys) disable iff (reset)
        askZero && !req_q |=> req_q && zero_q && fd_q == FD_IDLE)
        else $error("zero pause not requested below low mark");

    chk_jam_follows: assert property (
        @(posedge clk_sys) disable iff (reset)
        hdTrig ##1 (txEnable && !fullDuplex) |=> backpressure)
        else $error("matching frame not jammed");

    chk_tx_disabled: assert property (
        @(posedge clk_sys) disable iff (reset)
        !txEnable |=> !pauseReq && !backpressure)
        else $error("flow control active with transmitter disabled");

endmodule

// *** shared/rfct_pkg.sv ***
// Constants and types for the receive FIFO flow control trigger.
// Assumes one system clock at 100 MHz.
package rfct_pkg;

    localparam int CLK_NS = 10;
    // Back pressure is timed in ticks of 100 ns, so 2.2 us resolves exactly.
    localparam int TICK_NS = 100;
    localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;

    localparam int BP_SHORT_STEP_NS = 5000;
    localparam int BP_CODE3_NS = 25000;
    localparam int BP_LONG_STEP_NS = 50000;
    localparam int BP_10M_EXTRA_NS = 2200;

    localparam logic [12:0] BP_SHORT_TICKS = 13'(BP_SHORT_STEP_NS / TICK_NS);
    localparam logic [12:0] BP_CODE3_TICKS = 13'(BP_CODE3_NS / TICK_NS);
    localparam logic [12:0] BP_LONG_TICKS = 13'(BP_LONG_STEP_NS / TICK_NS);
    localparam logic [12:0] BP_10M_TICKS = 13'(BP_10M_EXTRA_NS / TICK_NS);

    localparam logic [3:0] BP_CODE_LONG_BASE = 4'h3;
    localparam int MARK_UNIT_SHIFT = 6;
    localparam int LEVEL_W = 14;

    localparam logic [7:0] MARK_RESET = 8'h00;
    localparam logic [3:0] BP_CODE_RESET = 4'h0;

    typedef enum logic [0:0] {
        FD_IDLE = 1'b0,
        FD_PAUSED = 1'b1
    } rfct_fd_state_type;

endpackage

// *** shared/rfct_timer_if.sv ***
// Link between the flow trigger and its back pressure timer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface rfct_timer_if;
    logic start;
    logic [3:0] code;
    logic speed100;
    logic busy;
    modport ctl (output start, output code, output speed100, input busy);
    modport tmr (input start, input code, input speed100, output busy);
endinterface

// *** testbench/rfct_link_partner.sv ***
// Remote link partner: sends frames as receive event pulses.
// Assumes the bench calls frame() from the falling clock edge.
`timescale 1ns/1ps
module rfct_link_partner (
    input wire logic clk_sys,
    output logic rxPreamble,
    output logic rxAddrDone,
    output logic rxIsGroup,
    output logic rxIsBroadcast,
    output logic rxIsOwn
);
    initial begin
        rxPreamble = 1'b0;
        rxAddrDone = 1'b0;
        {rxIsGroup, rxIsBroadcast, rxIsOwn} = 3'h5;
    end
    // Qualifiers are only valid with the decode pulse, so they show the
    // inverse of the last kind after it rather than a value that could pass by luck.
    task automatic frame(input logic pre, input logic [2:0] kind);
        @(negedge clk_sys);
        rxPreamble = pre;
        @(negedge clk_sys);
        rxPreamble = 1'b0;
        repeat (6) @(negedge clk_sys);
        rxAddrDone = 1'b1;
        {rxIsGroup, rxIsBroadcast, rxIsOwn} = kind;
        @(negedge clk_sys);
        rxAddrDone = 1'b0;
        {rxIsGroup, rxIsBroadcast, rxIsOwn} = ~kind;
    endtask
endmodule

// *** testbench/rfct_top_test.sv ***
// Self-checking bench for the receive FIFO flow control trigger.
// Assumes one tick of the jam timer per clock (BP_TICK_CYCLES of 1).
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin numChecks++; if ((got) !== (ex)) begin \
    numErrors++; $display("BAD %s expected %0h seen %0h", nm, ex, got); \
    end end
module rfct_top_test;
    import rfct_pkg::*;
    logic clk_sys, reset, flowCtlAnyFrame, flowCtlOnGroupFrame;
    logic flowCtlOnAllStationFrame, flowCtlOnOwnFrame;
    logic [7:0] flowHighMark, flowLowMark;
    logic [3:0] backpressureTimeCode;
    logic [LEVEL_W-1:0] rxFifoLevel;
    logic fullDuplex, speed100, txEnable, txWindow;
    logic rxPreamble, rxAddrDone, rxIsGroup, rxIsBroadcast, rxIsOwn;
    logic pauseReq, pauseZero, backpressure, highReached;
    int numErrors = 0, numChecks = 0, cycles = 0, len, lead, e;
    logic [3:0] slowCodes [3] = '{4'h0, 4'h3, 4'hF};
    rfct_top #(.BP_TICK_CYCLES(1)) i_dut (.clk_sys, .reset,
        .flowCtlAnyFrame, .flowCtlOnGroupFrame, .flowCtlOnAllStationFrame,
        .flowCtlOnOwnFrame, .flowHighMark, .flowLowMark,
        .backpressureTimeCode, .rxFifoLevel, .fullDuplex, .speed100,
        .txEnable, .rxPreamble, .rxAddrDone, .rxIsGroup, .rxIsBroadcast,
        .rxIsOwn, .txWindow, .pauseReq, .pauseZero, .backpressure,
        .highReached);
    rfct_link_partner lp (.clk_sys, .rxPreamble, .rxAddrDone, .rxIsGroup,
        .rxIsBroadcast, .rxIsOwn);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 80000) begin
            numErrors++;
            completeRun();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic completeRun();
        $display("checks %0d errors %0d", numChecks, numErrors);
        if (numErrors == 0 && numChecks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic grant();
        txWindow = 1'b1;
        settle(1);
        txWindow = 1'b0;
        settle(1);
    endtask
    function automatic int expTicks(input logic [3:0] c, input logic s);
        int ns;
        ns = c < 4'h3 ? (c + 1) * 5000 : c == 4'h3 ? 25000 : (c - 3) * 50000;
        return (ns + (s ? 0 : 2200)) / TICK_NS;
    endfunction
    // Sends one frame and measures how soon and how long the jam lasts.
    task automatic jam(input logic pre, input logic [2:0] kind,
                       input logic flip);
        fork
            lp.frame(pre, kind);
            begin
                len = 0;
                for (lead = 0; lead < 14 && !backpressure; lead++)
                    @(negedge clk_sys);
                if (flip) speed100 = ~speed100;
                while (backpressure === 1'b1 && len < 7000) begin
                    @(negedge clk_sys);
                    len++;
                end
            end
        join
        settle(2);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {flowCtlAnyFrame, flowCtlOnGroupFrame, flowCtlOnAllStationFrame} =
            3'h0;
        {flowCtlOnOwnFrame, txWindow, fullDuplex} = 3'h1;
        {speed100, txEnable, backpressureTimeCode} = 6'h30;
        flowHighMark = 8'h02;
        flowLowMark = 8'h01;
        rxFifoLevel = 14'h007F;
        reset = 1'b1;
        settle(4);
        reset = 1'b0;
        flowCtlOnOwnFrame = 1'b0;
        settle(3);
        `CHK("pause below mark", 1'b0, pauseReq)
        `CHK("high below mark", 1'b0, highReached)
        rxFifoLevel = 14'h0080;
        settle(3);
        `CHK("pause without any", 1'b0, pauseReq)
        `CHK("high at mark", 1'b1, highReached)
        flowCtlAnyFrame = 1'b1;
        settle(2);
        `CHK("pause at mark", 2'b10, {pauseReq, pauseZero})
        settle(5);
        `CHK("pause held", 1'b1, pauseReq)
        grant();
        `CHK("pause granted", 1'b0, pauseReq)
        rxFifoLevel = 14'h0040;
        settle(3);
        `CHK("no zero at low", 1'b0, pauseReq)
        rxFifoLevel = 14'h003F;
        settle(2);
        `CHK("zero pause", 2'b11, {pauseReq, pauseZero})
        grant();
        txEnable = 1'b0;
        rxFifoLevel = 14'h0080;
        settle(3);
        `CHK("pause tx off", 1'b0, pauseReq)
        jam(1'b1, 3'h0, 1'b0);
        `CHK("full duplex jam", 0, len)
        txEnable = 1'b1;
        settle(2);
        `CHK("pause tx on", 1'b1, pauseReq)
        grant();
        $display("test full duplex done");
        fullDuplex = 1'b0;
        for (int c = 0; c < 16; c++) begin
            backpressureTimeCode = 4'(c);
            jam(1'b1, 3'h0, 1'b0);
            e = expTicks(4'(c), 1'b1);
            `CHK("jam 100", 1'b1, len >= e && len <= e + 2)
            `CHK("jam on preamble", 1'b1, lead <= 5)
        end
        flowCtlOnGroupFrame = 1'b1;
        foreach (slowCodes[k]) begin
            backpressureTimeCode = slowCodes[k];
            speed100 = 1'b0;
            jam(1'b1, 3'h2, 1'b1);
            e = expTicks(backpressureTimeCode, 1'b0);
            `CHK("jam 10", 1'b1, len >= e && len <= e + 2)
        end
        $display("test duration done");
        speed100 = 1'b1;
        backpressureTimeCode = 4'h0;
        flowCtlAnyFrame = 1'b0;
        for (int i = 0; i < 3; i++) begin
            {flowCtlOnGroupFrame, flowCtlOnAllStationFrame,
             flowCtlOnOwnFrame} = 3'(1 << i);
            jam(1'b1, 3'(1 << i), 1'b0);
            `CHK("jam on match", 1'b1, len >= 50 && len <= 52)
            jam(1'b1, 3'(1 << ((i + 1) % 3)), 1'b0);
            `CHK("jam no match", 0, len)
        end
        flowCtlAnyFrame = 1'b1;
        jam(1'b0, 3'h4, 1'b0);
        `CHK("any skips address", 0, len)
        rxFifoLevel = 14'h007F;
        jam(1'b1, 3'h0, 1'b0);
        `CHK("jam below mark", 0, len)
        rxFifoLevel = 14'h0080;
        txEnable = 1'b0;
        jam(1'b1, 3'h0, 1'b0);
        `CHK("jam tx off", 0, len)
        $display("test half duplex done");
        completeRun();
    end
endmodule
